// [hw/gtps_pkg.sv]
// constants and types shared by both ends of the talker/poll link
//
// Contract
// - further talk address while talker: implied untalk
// - implied untalk armed by secondary; clears both
// - atn released, both flags: talk enable, drive
// - peripheral presents first byte on talk enable
// - one source handshake per byte until atn
// - atn drops talk enable, receive, acceptor on
// - untalk command clears both talk flags
// - controller asserts atn then untalk after data
// - poll starts: atn, unlisten, serial poll enable
// - unlisten clears listener flag
// - serial poll enable sets poll-active output
// - poll without talker: transceivers stay receive
// - foreign addresses decoded; own flags untouched except implied untalk
// - bit 7 set: controller sends untalk, disable (bench never reads bit 7)
// - bit 7 clear: next talk address, implied untalk (bench sends 8'h45 whatever bit 7 is)
// - serial poll disable clears poll-active output
// - talker during poll sends peripheral status byte
// - primary then secondary 109; enable after atn
// - interface clear clears every flag
package gtps_pkg;

  // ----------------------------------------------------------------------
  // bus command bytes
  // ----------------------------------------------------------------------
  localparam logic [7:0] GTPS_CMD_UNL     = 8'h3f;
  localparam logic [7:0] GTPS_CMD_UNT     = 8'h5f;
  localparam logic [7:0] GTPS_CMD_SPE     = 8'h18;
  localparam logic [7:0] GTPS_CMD_SPD     = 8'h19;
  localparam logic [7:0] GTPS_SEC_INPUT   = 8'h6d;
  localparam logic [1:0] GTPS_GRP_LISTEN  = 2'h1;
  localparam logic [1:0] GTPS_GRP_TALK    = 2'h2;
  localparam int         GTPS_GRP_LSB     = 5;
  localparam logic [4:0] GTPS_DEF_ADDR    = 5'h02;
  localparam int         GTPS_STATUS_BIT  = 7;

  // ----------------------------------------------------------------------
  // controller register map (apb byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] GTPS_REG_CTRL    = 8'h00;
  localparam logic [7:0] GTPS_REG_TX      = 8'h04;
  localparam logic [7:0] GTPS_REG_STATUS  = 8'h08;
  localparam logic [7:0] GTPS_REG_RX      = 8'h0c;
  localparam int         GTPS_CTRL_ATN    = 0;
  localparam int         GTPS_CTRL_IFC    = 1;
  localparam int         GTPS_ST_BUSY     = 0;
  localparam int         GTPS_ST_RXV      = 1;
  localparam logic [1:0] GTPS_CTRL_RST    = 2'h0;

  // ----------------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    GTPS_SH_IDLE = 2'b00,
    GTPS_SH_WACK = 2'b01,
    GTPS_SH_WREL = 2'b10
  } gtps_sh_e;

  typedef enum logic [1:0] {
    GTPS_TX_IDLE = 2'b00,
    GTPS_TX_DRV  = 2'b01,
    GTPS_TX_REL  = 2'b10
  } gtps_tx_e;

endpackage : gtps_pkg

// [hw/gtps_link_if.sv]
// link between the bus controller and the talker/poll device
`timescale 1ns/1ps
`default_nettype none
interface gtps_link_if;
  logic       atn;
  logic       ifc;
  logic       cdav;
  logic [7:0] cdio;
  logic       cack;
  logic       dack;
  logic       ddav;
  logic [7:0] ddio;
  logic       ddio_oe_n;

  modport ctrl (
    output atn,
    output ifc,
    output cdav,
    output cdio,
    output cack,
    input  dack,
    input  ddav,
    input  ddio,
    input  ddio_oe_n
  );

  modport dev (
    input  atn,
    input  ifc,
    input  cdav,
    input  cdio,
    input  cack,
    output dack,
    output ddav,
    output ddio,
    output ddio_oe_n
  );
endinterface : gtps_link_if
`default_nettype wire

// [hw/gtps_device.sv]
// device end: talk and poll addressing flags with source handshake
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module gtps_device
  import gtps_pkg::*;
#(
  parameter logic [4:0] MY_ADDR = GTPS_DEF_ADDR
) (
  input  wire logic       clk,
  input  wire logic       srst,
  gtps_link_if.dev        link,
  input  wire logic       periph_valid,
  input  wire logic [7:0] periph_data,
  output var  logic       periph_taken,
  output var  logic       talk_enable_out,
  output var  logic       listen_enable_out,
  output var  logic       serial_poll_active
);

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  logic       ptalk_r;
  logic       ptalk_nxt;
  logic       stalk_r;
  logic       stalk_nxt;
  logic       lsn_r;
  logic       lsn_nxt;
  logic       poll_r;
  logic       poll_nxt;
  logic       dack_r;
  logic       dack_nxt;
  logic       ten_r;
  logic       ten_nxt;
  logic       len_r;
  logic       len_nxt;
  logic       oe_n_r;
  logic       oe_n_nxt;
  logic       cmd_stb;
  logic [7:0] cmd;
  logic       is_talk;
  logic       my_talk;
  logic       my_listen;

  assign cmd       = link.cdio;
  assign cmd_stb   = link.atn & link.cdav & ~dack_r;
  assign is_talk   = cmd[6:GTPS_GRP_LSB] == GTPS_GRP_TALK
                     && cmd != GTPS_CMD_UNT;
  assign my_talk   = is_talk && cmd[4:0] == MY_ADDR;
  assign my_listen = cmd[6:GTPS_GRP_LSB] == GTPS_GRP_LISTEN
                     && cmd[4:0] == MY_ADDR;

  // ----------------------------------------------------------------------
  // addressing and poll flags
  // ----------------------------------------------------------------------
  always_comb begin
    ptalk_nxt = ptalk_r;
    stalk_nxt = stalk_r;
    lsn_nxt   = lsn_r;
    poll_nxt  = poll_r;
    if (link.ifc) begin
      ptalk_nxt = 1'b0;
      stalk_nxt = 1'b0;
      lsn_nxt   = 1'b0;
      poll_nxt  = 1'b0;
    end else if (cmd_stb) begin
      if (cmd == GTPS_CMD_UNT) begin
        ptalk_nxt = 1'b0;
        stalk_nxt = 1'b0;
      end else if (is_talk && stalk_r) begin
        ptalk_nxt = 1'b0;
        stalk_nxt = 1'b0;
      end else if (my_talk) begin
        ptalk_nxt = 1'b1;
      end else if (cmd == GTPS_SEC_INPUT && ptalk_r) begin
        stalk_nxt = 1'b1;
      end
      // with stalk_r clear, foreign talk addresses fall through unchanged
      if (cmd == GTPS_CMD_UNL) begin
        lsn_nxt = 1'b0;
      end else if (my_listen) begin
        lsn_nxt = 1'b1;
      end
      if (cmd == GTPS_CMD_SPE) begin
        poll_nxt = 1'b1;
      end else if (cmd == GTPS_CMD_SPD) begin
        poll_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ptalk_r <= 1'b0;
      stalk_r <= 1'b0;
      lsn_r   <= 1'b0;
      poll_r  <= 1'b0;
    end else begin
      ptalk_r <= ptalk_nxt;
      stalk_r <= stalk_nxt;
      lsn_r   <= lsn_nxt;
      poll_r  <= poll_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // enables, transceiver direction and acceptor
  // ----------------------------------------------------------------------
  always_comb begin
    ten_nxt  = ptalk_nxt & stalk_nxt & ~link.atn;
    len_nxt  = lsn_nxt & ~link.atn;
    oe_n_nxt = ~ten_nxt;
    dack_nxt = link.cdav & ~ten_r & ~link.ifc;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ten_r  <= 1'b0;
      len_r  <= 1'b0;
      oe_n_r <= 1'b1;
      dack_r <= 1'b0;
    end else begin
      ten_r  <= ten_nxt;
      len_r  <= len_nxt;
      oe_n_r <= oe_n_nxt;
      dack_r <= dack_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // source handshake
  // ----------------------------------------------------------------------
  gtps_sh_e   sh_r;
  gtps_sh_e   sh_nxt;
  logic       ddav_r;
  logic       ddav_nxt;
  logic [7:0] ddio_r;
  logic [7:0] ddio_nxt;
  logic       taken_r;
  logic       taken_nxt;

  always_comb begin
    sh_nxt    = sh_r;
    ddav_nxt  = ddav_r;
    ddio_nxt  = ddio_r;
    taken_nxt = 1'b0;
    case (sh_r)
      GTPS_SH_IDLE: begin
        if (ten_r && ten_nxt && periph_valid) begin
          ddio_nxt  = periph_data;
          ddav_nxt  = 1'b1;
          taken_nxt = 1'b1;
          sh_nxt    = GTPS_SH_WACK;
        end
      end
      GTPS_SH_WACK: begin
        if (link.atn || link.ifc) begin
          ddav_nxt = 1'b0;
          sh_nxt   = GTPS_SH_WREL;
        end else if (link.cack) begin
          ddav_nxt = 1'b0;
          sh_nxt   = GTPS_SH_WREL;
        end
      end
      GTPS_SH_WREL: begin
        if (!link.cack) begin
          sh_nxt = GTPS_SH_IDLE;
        end
      end
      default: begin
        ddav_nxt = 1'b0;
        sh_nxt   = GTPS_SH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sh_r    <= GTPS_SH_IDLE;
      ddav_r  <= 1'b0;
      ddio_r  <= 8'h00;
      taken_r <= 1'b0;
    end else begin
      sh_r    <= sh_nxt;
      ddav_r  <= ddav_nxt;
      ddio_r  <= ddio_nxt;
      taken_r <= taken_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign link.dack          = dack_r;
  assign link.ddav          = ddav_r;
  assign link.ddio          = ddio_r;
  assign link.ddio_oe_n     = oe_n_r;
  assign talk_enable_out    = ten_r;
  assign listen_enable_out  = len_r;
  assign serial_poll_active = poll_r;
  assign periph_taken       = taken_r;

endmodule : gtps_device
`default_nettype wire

// [hw/gtps_ctrl.sv]
// controller end: apb registers drive atn, ifc, commands and data intake
`timescale 1ns/1ps
`default_nettype none
module gtps_ctrl
  import gtps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  gtps_link_if.ctrl        link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr
);

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic        setup;
  logic        wr;
  logic        rd;
  logic        rdy_r;
  logic        rdy_nxt;
  logic [1:0]  ctrl_r;
  logic [1:0]  ctrl_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        err_r;
  logic        err_nxt;
  logic        rxv_r;
  logic        rxv_nxt;
  logic [7:0]  rx_r;
  logic [7:0]  rx_nxt;
  logic        cack_r;
  logic        cack_nxt;
  gtps_tx_e    tx_r;
  gtps_tx_e    tx_nxt;
  logic        cdav_r;
  logic        cdav_nxt;
  logic [7:0]  cdio_r;
  logic [7:0]  cdio_nxt;

  // read data registered at setup, writes applied at the access edge
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite;
  assign rd    = psel & penable & ~pwrite;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    prdata_nxt = 32'h0000_0000;
    err_nxt    = 1'b0;
    rdy_nxt    = setup;
    if (wr && paddr == GTPS_REG_CTRL) begin
      ctrl_nxt = pwdata[1:0];
    end
    if (setup) begin
      if (paddr == GTPS_REG_CTRL) begin
        prdata_nxt[1:0] = ctrl_r;
      end else if (paddr == GTPS_REG_TX) begin
        prdata_nxt[7:0] = cdio_r;
      end else if (paddr == GTPS_REG_STATUS) begin
        prdata_nxt[GTPS_ST_BUSY] = tx_r != GTPS_TX_IDLE;
        prdata_nxt[GTPS_ST_RXV]  = rxv_r;
      end else if (paddr == GTPS_REG_RX) begin
        prdata_nxt[7:0] = rx_r;
      end else begin
        err_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // command sender
  // ----------------------------------------------------------------------
  always_comb begin
    tx_nxt   = tx_r;
    cdav_nxt = cdav_r;
    cdio_nxt = cdio_r;
    case (tx_r)
      GTPS_TX_IDLE: begin
        if (wr && paddr == GTPS_REG_TX) begin
          cdio_nxt = pwdata[7:0];
          cdav_nxt = 1'b1;
          tx_nxt   = GTPS_TX_DRV;
        end
      end
      GTPS_TX_DRV: begin
        if (link.dack) begin
          cdav_nxt = 1'b0;
          tx_nxt   = GTPS_TX_REL;
        end
      end
      GTPS_TX_REL: begin
        if (!link.dack) begin
          tx_nxt = GTPS_TX_IDLE;
        end
      end
      default: begin
        cdav_nxt = 1'b0;
        tx_nxt   = GTPS_TX_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // acceptor for talker data and status bytes
  // ----------------------------------------------------------------------
  always_comb begin
    rx_nxt   = rx_r;
    rxv_nxt  = rxv_r;
    cack_nxt = cack_r;
    if (rd && paddr == GTPS_REG_RX) begin
      rxv_nxt = 1'b0;
    end
    if (!cack_r && link.ddav && !ctrl_r[GTPS_CTRL_ATN] && !rxv_r) begin
      rx_nxt   = link.ddio;
      rxv_nxt  = 1'b1;
      cack_nxt = 1'b1;
    end else if (cack_r && !link.ddav) begin
      cack_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r   <= GTPS_CTRL_RST;
      prdata_r <= 32'h0000_0000;
      err_r    <= 1'b0;
      rdy_r    <= 1'b0;
      tx_r     <= GTPS_TX_IDLE;
      cdav_r   <= 1'b0;
      cdio_r   <= 8'h00;
      rx_r     <= 8'h00;
      rxv_r    <= 1'b0;
      cack_r   <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      err_r    <= err_nxt;
      rdy_r    <= rdy_nxt;
      tx_r     <= tx_nxt;
      cdav_r   <= cdav_nxt;
      cdio_r   <= cdio_nxt;
      rx_r     <= rx_nxt;
      rxv_r    <= rxv_nxt;
      cack_r   <= cack_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign link.atn  = ctrl_r[GTPS_CTRL_ATN];
  assign link.ifc  = ctrl_r[GTPS_CTRL_IFC];
  assign link.cdav = cdav_r;
  assign link.cdio = cdio_r;
  assign link.cack = cack_r;
  assign prdata    = prdata_r;
  assign pslverr   = err_r;
  assign pready    = rdy_r;

endmodule : gtps_ctrl
`default_nettype wire

// [verif/gtps_chk.sv]
// assertions on the link between controller and device
`timescale 1ns/1ps
`default_nettype none
module gtps_chk
  import gtps_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       atn,
  input wire logic       ifc,
  input wire logic       cdav,
  input wire logic [7:0] cdio,
  input wire logic       cack,
  input wire logic       dack,
  input wire logic       ddav,
  input wire logic [7:0] ddio,
  input wire logic       ddio_oe_n,
  input wire logic       talk_enable_out,
  input wire logic       listen_enable_out,
  input wire logic       serial_poll_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // --------------------------------------------------------------------
  // command link
  // --------------------------------------------------------------------
  sequence s_cmd(b);
    atn && cdav && !dack && cdio == b;
  endsequence
  property p_cmd_ack;
    atn && cdav && !dack && !talk_enable_out && !ifc |=> dack;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack) else $error("no ack");
  property p_dack_rel;
    dack && !cdav |=> !dack;
  endproperty
  a_dack_rel: assert property (p_dack_rel) else $error("ack held");
  property p_spe;
    s_cmd(GTPS_CMD_SPE) |-> ##[1:3] serial_poll_active;
  endproperty
  a_spe: assert property (p_spe) else $error("poll not set");
  property p_spd;
    s_cmd(GTPS_CMD_SPD) |-> ##[1:3] !serial_poll_active;
  endproperty
  a_spd: assert property (p_spd) else $error("poll not cleared");
  // --------------------------------------------------------------------
  // talker side
  // --------------------------------------------------------------------
  property p_atn_drop;
    $rose(atn) |=> !talk_enable_out && ddio_oe_n;
  endproperty
  a_atn_drop: assert property (p_atn_drop) else $error("talk kept");
  property p_talk_atn;
    talk_enable_out |-> !$past(atn);
  endproperty
  a_talk_atn: assert property (p_talk_atn) else $error("talk in atn");
  property p_oe;
    !ddio_oe_n |-> talk_enable_out;
  endproperty
  a_oe: assert property (p_oe) else $error("drive not talker");
  property p_ddav;
    ddav && !cack && !atn && !ifc |=> ddav && $stable(ddio);
  endproperty
  a_ddav: assert property (p_ddav) else $error("byte dropped");
  property p_ifc;
    ifc |=> !talk_enable_out && !listen_enable_out && !serial_poll_active;
  endproperty
  a_ifc: assert property (p_ifc) else $error("clear missed");
endmodule : gtps_chk
`default_nettype wire

// [verif/gtps_talker_poll_state_tb.sv]
// testbench for both ends of the talker/poll link
`timescale 1ns/1ps
`default_nettype none
module gpib_talker_poll_state_tb
  import gtps_pkg::*;
;
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, periph_data = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, periph_valid = 0, periph_taken;
  logic        talk, lstn, spa;
  logic [7:0]  exp_q[$];
  int          checks = 0, bad_count = 0, seed;
  gtps_link_if gtps_link_if_i();
  gtps_ctrl gtps_ctrl_i(.clk, .srst, .link(gtps_link_if_i), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  gtps_device #(.MY_ADDR(5'h02)) gtps_device_i(.clk, .srst,
    .link(gtps_link_if_i), .periph_valid, .periph_data, .periph_taken,
    .talk_enable_out(talk), .listen_enable_out(lstn),
    .serial_poll_active(spa));
  gtps_chk gtps_chk_i(.clk, .srst, .atn(gtps_link_if_i.atn),
    .ifc(gtps_link_if_i.ifc), .cdav(gtps_link_if_i.cdav),
    .cdio(gtps_link_if_i.cdio), .cack(gtps_link_if_i.cack),
    .dack(gtps_link_if_i.dack), .ddav(gtps_link_if_i.ddav),
    .ddio(gtps_link_if_i.ddio), .ddio_oe_n(gtps_link_if_i.ddio_oe_n),
    .talk_enable_out(talk), .listen_enable_out(lstn),
    .serial_poll_active(spa));
  always #2 clk = ~clk;
  // --------------------------------------------------------------------
  // checking and bus tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic give_up;
    bad_count++;
    wrap_up();
  endtask : give_up
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) give_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, GTPS_REG_STATUS, 32'h0);
      n++;
    end while (rd[b] !== v && n < 30);
    if (rd[b] !== v) give_up();
  endtask : wait_st
  task automatic cmd(input logic [7:0] b);
    apb(1'b1, GTPS_REG_TX, {24'h0, b});
    wait_st(GTPS_ST_BUSY, 1'b0);
  endtask : cmd
  task automatic set_atn(input logic v);
    apb(1'b1, GTPS_REG_CTRL, {31'h0, v});
    repeat (3) @(posedge clk);
  endtask : set_atn
  task automatic talk_byte;
    logic [7:0] b;
    int n;
    b = 8'($random(seed));
    periph_data <= b;
    periph_valid <= 1'b1;
    exp_q.push_back(b);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (periph_taken !== 1'b1 && n < 30);
    if (periph_taken !== 1'b1) give_up();
    periph_valid <= 1'b0;
    wait_st(GTPS_ST_RXV, 1'b1);
    apb(1'b0, GTPS_REG_RX, 32'h0);
  endtask : talk_byte
  // --------------------------------------------------------------------
  // received byte watcher
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite
        && paddr == GTPS_REG_RX && exp_q.size() > 0) begin
      chk(prdata, {24'h0, exp_q.pop_front()}, "rx byte");
    end
  end
  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    seed = 32'had041bcd;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, GTPS_REG_CTRL, 32'h0);
    chk(rd, {30'h0, GTPS_CTRL_RST}, "ctrl reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    chk({talk, lstn, spa}, 3'b000, "flags reset");
    set_atn(1'b1);
    cmd(8'h42);
    cmd(GTPS_SEC_INPUT);
    chk(talk, 1'b0, "talk under atn");
    set_atn(1'b0);
    chk({talk, gtps_link_if_i.ddio_oe_n}, 2'b10, "talker");
    talk_byte();
    talk_byte();
    set_atn(1'b1);
    chk({talk, gtps_link_if_i.ddio_oe_n}, 2'b01, "atn drop");
    cmd(GTPS_CMD_UNT);
    set_atn(1'b0);
    chk(talk, 1'b0, "untalk");
    set_atn(1'b1);
    cmd(8'h22);
    set_atn(1'b0);
    chk(lstn, 1'b1, "listener");
    set_atn(1'b1);
    cmd(GTPS_CMD_UNL);
    cmd(GTPS_CMD_SPE);
    chk(spa, 1'b1, "poll on");
    set_atn(1'b0);
    chk(lstn, 1'b0, "unlisten");
    set_atn(1'b1);
    cmd(8'h43);
    cmd(GTPS_SEC_INPUT);
    set_atn(1'b0);
    chk({talk, gtps_link_if_i.ddio_oe_n}, 2'b01, "foreign");
    set_atn(1'b1);
    cmd(8'h42);
    cmd(GTPS_SEC_INPUT);
    set_atn(1'b0);
    chk(talk, 1'b1, "poll talker");
    talk_byte();
    set_atn(1'b1);
    cmd(8'h45);
    set_atn(1'b0);
    chk(talk, 1'b0, "implied untalk");
    set_atn(1'b1);
    cmd(GTPS_CMD_SPD);
    chk(spa, 1'b0, "poll off");
    cmd(GTPS_CMD_SPE);
    apb(1'b1, GTPS_REG_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    chk({talk, lstn, spa}, 3'b000, "clear");
    apb(1'b1, GTPS_REG_CTRL, 32'h0);
    wrap_up();
  end
endmodule : gpib_talker_poll_state_tb
`default_nettype wire
